// file: include/bpg_pkg.sv
package bpg_pkg;
  // picture geometry limits
  localparam int unsigned MB_ROWS_W     = 6;
  localparam int unsigned LINE_W        = 10;
  localparam logic [5:0]  MB_ROWS_RST   = 6'h0f;
  localparam logic [9:0]  LINES_PER_MB  = 10'h010;
  localparam logic [9:0]  BOTTOM_LEAD   = 10'h010;
  // progress fractions in hundredths
  localparam logic [6:0]  PCT_PRE       = 7'h37;
  localparam logic [6:0]  PCT_REMAIN    = 7'h2d;
  localparam logic [6:0]  PCT_FULL      = 7'h64;
  // fixed point for the decoded-row estimate
  localparam int unsigned FRAC_W        = 16;
  localparam int unsigned ACC_W         = MB_ROWS_W + FRAC_W;
  localparam logic [9:0]  WIN_LINES_RST = 10'h0f0;
  localparam logic [9:0]  TOP_RST       = 10'h000;
  localparam logic [9:0]  TOP_MIN       = 10'h000;

  typedef enum logic [2:0] {
    BPG_IDLE   = 3'b001,
    BPG_BORDER = 3'b010,
    BPG_SHOW   = 3'b100
  } bpg_state_t;
endpackage

// file: hw/bpg_sync2.sv
`timescale 1ns/1ps
module bpg_sync2 (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // async level in, synchronised level out
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_reg;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

// file: hw/bpg_guard.sv
`timescale 1ns/1ps
// What this block does
// - scan-out of a B-picture starts while its decode is still running
// - about 55% of macroblocks are decoded before the earliest shown line
// - up to 45% of macroblocks remain at the close of the top border
// - after display starts, decoded rows count up at a constant rate per line
// - all macroblocks decoded 16 lines before the bottom border begins
// - the decoded-row estimate truncates to whole macroblock rows
// - a lower window start means more picture decoded at first line
// - the last row is never displayable above its default position
module bpg_guard
  import bpg_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // display timing pins
  input  wire logic                 hsync_in,
  input  wire logic                 vsync_in,
  // host command fields
  input  wire logic                 window_placement_command_in,
  input  wire logic [LINE_W-1:0]    window_lines_in,
  input  wire logic                 border_setup_command_in,
  input  wire logic [LINE_W-1:0]    top_margin_lines_in,
  input  wire logic [MB_ROWS_W-1:0] pic_mb_rows_in,
  // decoder core
  input  wire logic                 bpic_start_in,
  // status
  output logic                      displaying_out,
  output logic [MB_ROWS_W-1:0]      rows_decoded_out,
  output logic [MB_ROWS_W-1:0]      row_shown_out,
  output logic                      row_ok_out,
  output logic                      glitch_out,
  output logic                      decode_done_out
);
  import bpg_pkg::*;

  logic                 hs_sync;
  logic                 vs_sync;
  logic                 hs_d_reg;
  logic                 vs_d_reg;
  logic                 line_tick;
  logic                 frame_tick;
  bpg_state_t           state_reg;
  logic [LINE_W-1:0]    win_lines_reg;
  logic [LINE_W-1:0]    top_reg;
  logic [MB_ROWS_W-1:0] mb_rows_reg;
  logic [LINE_W-1:0]    line_reg;
  logic [LINE_W-1:0]    rate_lines;
  logic [ACC_W-1:0]     acc_reg;
  logic [ACC_W-1:0]     acc_next;
  logic [ACC_W-1:0]     step_reg;
  logic [ACC_W-1:0]     acc_full;
  logic [ACC_W-1:0]     acc_pre;
  logic [ACC_W-1:0]     acc_step;
  logic [MB_ROWS_W-1:0] row_now;

  bpg_sync2 u_hs (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (hsync_in),
    .q_out    (hs_sync)
  );
  bpg_sync2 u_vs (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .d_in     (vsync_in),
    .q_out    (vs_sync)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hs_d_reg <= 1'b0;
      vs_d_reg <= 1'b0;
    end else begin
      hs_d_reg <= hs_sync;
      vs_d_reg <= vs_sync;
    end
  end
  assign line_tick  = hs_sync & ~hs_d_reg;
  assign frame_tick = vs_sync & ~vs_d_reg;

  // host settings, held until the next command
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      win_lines_reg <= WIN_LINES_RST;
      top_reg       <= TOP_RST;
    end else begin
      if (window_placement_command_in)
        win_lines_reg <= window_lines_in;
      if (border_setup_command_in)
        top_reg <= top_margin_lines_in;
    end
  end

  // fixed point: rows << FRAC_W
  assign acc_full = {mb_rows_reg, {FRAC_W{1'b0}}};
  // 55% pre-decoded, up to 45% left at end of top border; 32-bit products, since
  // rows times percent shifted by the fraction outgrows the accumulator
  assign acc_pre  = ACC_W'((32'(pic_mb_rows_in) * 32'(PCT_PRE) << FRAC_W) / 32'(PCT_FULL));
  // lines available to finish: window height less the bottom lead
  assign rate_lines = (win_lines_reg > BOTTOM_LEAD) ? (win_lines_reg - BOTTOM_LEAD) : 10'h001;
  // round the rate up so completion never falls after the deadline
  assign acc_step = ACC_W'(((32'(pic_mb_rows_in) * 32'(PCT_REMAIN) << FRAC_W) / 32'(PCT_FULL)
                    + 32'(rate_lines) - 32'h1) / 32'(rate_lines));

  // picture state: border then overlapped display
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg   <= BPG_IDLE;
      mb_rows_reg <= MB_ROWS_RST;
      step_reg    <= '0;
      line_reg    <= '0;
    end else begin
      unique case (state_reg)
        BPG_IDLE: begin
          if (bpic_start_in) begin
            state_reg   <= BPG_BORDER;
            mb_rows_reg <= pic_mb_rows_in;
            step_reg    <= acc_step;
            line_reg    <= '0;
          end
        end
        BPG_BORDER: begin
          if (line_tick) begin
            if (line_reg >= top_reg) begin
              state_reg <= BPG_SHOW;
              line_reg  <= '0;
            end else begin
              line_reg <= line_reg + 10'h001;
            end
          end
        end
        BPG_SHOW: begin
          if (frame_tick)
            state_reg <= BPG_IDLE;
          else if (line_tick && line_reg < win_lines_reg)
            line_reg <= line_reg + 10'h001;
        end
        default: state_reg <= BPG_IDLE;
      endcase
    end
  end

  // progress estimate; decode runs through the border too, so a lower
  // window start shows more of the picture done at its first line
  always_comb begin
    acc_next = acc_reg;
    if (state_reg == BPG_IDLE && bpic_start_in)
      acc_next = acc_pre;
    else if (line_tick && (state_reg == BPG_SHOW || (state_reg == BPG_BORDER && line_reg < top_reg)))
      acc_next = ((acc_reg + step_reg) > acc_full) ? acc_full : (acc_reg + step_reg);
    if (state_reg == BPG_SHOW && line_tick && (line_reg + BOTTOM_LEAD + 10'h001) >= win_lines_reg)
      acc_next = acc_full;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      acc_reg <= '0;
    else
      acc_reg <= acc_next;
  end

  assign row_now = MB_ROWS_W'(line_reg / LINES_PER_MB);

  // outputs; estimate truncated to whole rows, so the last row is never
  // cleared before its default line position
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      displaying_out   <= 1'b0;
      rows_decoded_out <= '0;
      row_shown_out    <= '0;
      row_ok_out       <= 1'b0;
      glitch_out       <= 1'b0;
      decode_done_out  <= 1'b0;
    end else begin
      displaying_out   <= (state_reg == BPG_SHOW);
      rows_decoded_out <= acc_reg[ACC_W-1:FRAC_W];
      row_shown_out    <= row_now;
      decode_done_out  <= (acc_reg == acc_full) && (state_reg != BPG_IDLE);
      row_ok_out       <= (state_reg == BPG_SHOW) && (row_now < acc_reg[ACC_W-1:FRAC_W]);
      if (state_reg == BPG_IDLE && bpic_start_in)
        glitch_out <= 1'b0;
      else if (state_reg == BPG_SHOW && line_tick && row_now >= acc_reg[ACC_W-1:FRAC_W])
        glitch_out <= 1'b1;
    end
  end

  a_est_truncated: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ##1 rows_decoded_out == $past(acc_reg[ACC_W-1:FRAC_W]))
    else $error("row estimate not truncated acc");
  a_est_monotone: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == BPG_SHOW && !line_tick) |=> acc_reg == $past(acc_reg))
    else $error("estimate moved without a line");
  a_done_bounded: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == BPG_SHOW && line_tick && (line_reg + BOTTOM_LEAD + 10'h001) >= win_lines_reg)
    |=> acc_reg == acc_full)
    else $error("decode not complete before bottom lead");
  a_start_pre: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == BPG_IDLE && bpic_start_in) |=> state_reg == BPG_BORDER && acc_reg == $past(acc_pre))
    else $error("pre-decode fraction not loaded");
  a_show_overlap: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == BPG_BORDER && line_tick && line_reg >= top_reg) |=> state_reg == BPG_SHOW)
    else $error("display did not start at border end");
  a_glitch_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (state_reg == BPG_SHOW && line_tick && row_now >= acc_reg[ACC_W-1:FRAC_W]) |=> glitch_out)
    else $error("early row not flagged");
  a_never_over: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    acc_reg <= acc_full || state_reg == BPG_IDLE)
    else $error("estimate passed picture height");
  a_row_ok: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    row_ok_out |-> $past(state_reg == BPG_SHOW))
    else $error("row ok outside display");
endmodule

// file: sim/bpg_disp_model.sv
`timescale 1ns/1ps
module bpg_disp_model (
  // clock
  input  wire logic clk_in,
  // display timing pins
  output logic      hsync_out,
  output logic      vsync_out
);
  initial begin
    hsync_out = 1'b0;
    vsync_out = 1'b0;
  end
  // fixed 64-cycle line period; the guard steps its estimate per line, not per cycle
  task automatic lines(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in) hsync_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      hsync_out <= 1'b0;
      repeat (59) @(posedge clk_in);
    end
  endtask
  // pulse long enough to pass the pin synchroniser
  task automatic frame_end();
    @(posedge clk_in) vsync_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    vsync_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import bpg_pkg::*;
  typedef struct { logic [5:0] rows; logic [5:0] pre; } bpg_row_t;
  logic       clk_in = 1'b0;
  logic       rst_n_in;
  logic       hsync, vsync;
  logic       win_cmd, top_cmd, start_in;
  logic [9:0] win_lines, top_lines;
  logic [5:0] pic_rows;
  logic       disp, row_ok, glitch, done;
  logic [5:0] rows_dec, row_shown;
  int         n_fail = 0;
  int         samples_checked = 0;
  // non-integer 55% products only, so fixed point rounding cannot tip them
  bpg_row_t   tab [4] = '{'{6'h0f, 6'h08}, '{6'h0a, 6'h05}, '{6'h3f, 6'h22}, '{6'h01, 6'h00}};

  always #2 clk_in = ~clk_in;

  bpg_disp_model i_disp (.clk_in(clk_in), .hsync_out(hsync), .vsync_out(vsync));
  bpg_guard i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .hsync_in(hsync), .vsync_in(vsync),
    .window_placement_command_in(win_cmd), .window_lines_in(win_lines),
    .border_setup_command_in(top_cmd), .top_margin_lines_in(top_lines),
    .pic_mb_rows_in(pic_rows), .bpic_start_in(start_in), .displaying_out(disp),
    .rows_decoded_out(rows_dec), .row_shown_out(row_shown), .row_ok_out(row_ok),
    .glitch_out(glitch), .decode_done_out(done));

  task automatic check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmd(input logic is_win, input logic [9:0] v);
    @(posedge clk_in);
    if (is_win) begin
      win_lines <= v;
      win_cmd <= 1'b1;
    end else begin
      top_lines <= v;
      top_cmd <= 1'b1;
    end
    @(posedge clk_in);
    win_cmd <= 1'b0;
    top_cmd <= 1'b0;
  endtask
  task automatic start(input logic [5:0] rows);
    @(posedge clk_in);
    pic_rows <= rows;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask

  initial begin
    #(4 * 60000);
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_n_in <= 1'b0;
    win_cmd <= 1'b0;
    top_cmd <= 1'b0;
    start_in <= 1'b0;
    win_lines <= 10'h0f0;
    top_lines <= 10'h000;
    pic_rows <= 6'h0f;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    #1;
    check("displaying", disp, 1'b0);
    check("rows_decoded", rows_dec, 6'h00);
    check("glitch", glitch, 1'b0);
    $display("test reset done");
    foreach (tab[i]) begin
      start(tab[i].rows);
      check("pre_estimate", rows_dec, tab[i].pre);
      i_disp.lines(1);
      check("displaying", disp, 1'b1);
      i_disp.frame_end();
      check("displaying", disp, 1'b0);
    end
    $display("test table done");
    cmd(1'b1, 10'h0f0);
    start(6'h0f);
    i_disp.lines(11);
    start(6'h02);
    i_disp.lines(189);
    check("rows_decoded", rows_dec, 6'h0e);
    check("decode_done", done, 1'b0);
    check("row_shown", row_shown, 6'h0c);
    check("row_ok", row_ok, 1'b1);
    i_disp.lines(30);
    check("decode_done", done, 1'b1);
    check("rows_decoded", rows_dec, 6'h0f);
    check("glitch", glitch, 1'b0);
    i_disp.frame_end();
    $display("test full picture done");
    start(6'h02);
    i_disp.lines(20);
    check("glitch", glitch, 1'b1);
    check("row_ok", row_ok, 1'b0);
    i_disp.frame_end();
    start(6'h0f);
    check("glitch", glitch, 1'b0);
    i_disp.lines(1);
    i_disp.frame_end();
    $display("test glitch done");
    cmd(1'b0, 10'h004);
    start(6'h0f);
    i_disp.lines(2);
    check("displaying", disp, 1'b0);
    i_disp.lines(6);
    check("displaying", disp, 1'b1);
    i_disp.frame_end();
    cmd(1'b0, 10'h000);
    $display("test border done");
    print_verdict();
  end
endmodule
